// >>> logic/mtcs_defines.svh
// Constants of the test-command sequencer: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the package and the design module.
`ifndef MTCS_DEFINES_SVH
`define MTCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Chip register indices (byte address on APB is four times the index)
// ----------------------------------------------------------------------
`define MTCS_GC_IDX 8'he0
`define MTCS_TX_IDX 8'he1
`define MTCS_RX_IDX 8'he2
`define MTCS_ST_IDX 8'he6
`define MTCS_CHIP_BASE 8'he0

// ----------------------------------------------------------------------
// Own APB registers (byte addresses and reset values)
// ----------------------------------------------------------------------
`define MTCS_CTRL_ADDR 12'h000
`define MTCS_IRQ_ST_ADDR 12'h004
`define MTCS_IRQ_MK_ADDR 12'h008
`define MTCS_STATE_ADDR 12'h00c
`define MTCS_CTRL_RST 9'h00e
`define MTCS_IRQ_RST 3'h0

// ----------------------------------------------------------------------
// Chip word fields
// ----------------------------------------------------------------------
`define MTCS_MODE_HI 15
`define MTCS_MODE_LO 12
`define MTCS_LEVEL_HI 11
`define MTCS_LEVEL_LO 9
`define MTCS_MODE_TONES 4'h1
`define MTCS_LEVEL_0DB 3'h7
`define MTCS_TONE_OFF 4'h0
`define MTCS_TONE_A 4'hd
`define MTCS_TONE_B 4'he
`define MTCS_GC_EQU_DIS 10
`define MTCS_GC_OFF_HOOK 9
`define MTCS_GC_PWR_UP 8
`define MTCS_GC_RESET 7
`define MTCS_GC_IRQ_EN 6
`define MTCS_GC_XTAL 12

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define MTCS_CLK_PERIOD_NS 20
`define MTCS_TENTH_SEC_NS 100000000

// ----------------------------------------------------------------------
// Characters and message table starts
// ----------------------------------------------------------------------
`define MTCS_CR 8'h0d
`define MTCS_MSG_OK 5'h00
`define MTCS_MSG_ERROR 5'h03
`define MTCS_MSG_NOCAR 5'h09

`endif

// >>> logic/mtcs_pkg.sv
// Types of the test-command sequencer.
// Assumes the defines header is on the include path.
`include "mtcs_defines.svh"

package mtcs_pkg;

    // ------------------------------------------------------------------
    // State machines
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_DEC = 3'h1,
        S_CHIP = 3'h3,
        S_SEND = 3'h2,
        S_DELAY = 3'h6,
        S_WIRQ = 3'h7
    } main_e;

    typedef enum logic [3:0] {
        P_A = 4'h0,
        P_T = 4'h1,
        P_CMD = 4'h3,
        P_AT = 4'h2,
        P_R = 4'h6,
        P_E = 4'h7,
        P_REG = 4'h5,
        P_NUM = 4'h4,
        P_F = 4'hc,
        P_H = 4'hd,
        P_SKIP = 4'hf
    } parse_e;

    // ------------------------------------------------------------------
    // Whole state of the sequencer
    // ------------------------------------------------------------------
    typedef struct packed {
        main_e st;
        parse_e ps;
        logic [7:0] ch;
        logic [3:0] creg;
        logic [15:0] acc;
        logic line_err;
        logic [31:0] cnt;
        logic [31:0] cd_cnt;
        logic cd_lost;
        logic hook;
        logic req;
        logic wr;
        logic [7:0] addr;
        logic [15:0] wdata;
        logic [15:0] sh_gc;
        logic [15:0] sh_tx;
        logic [15:0] sh_rx;
        logic [15:0] sh_stat;
        logic [15:0] rd_val;
        logic tx_valid;
        logic [7:0] tx_char;
        logic snd_hex;
        logic snd_last;
        logic [4:0] snd_idx;
        logic rx_ready;
        logic [8:0] ctrl;
        logic [2:0] irq_st;
        logic [2:0] irq_mk;
        logic irq;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [1:0] irq_sync;
        logic [1:0] cd_sync;
    } seq_state_s;

endpackage

// >>> logic/modem_test_command_sequencer.sv
// Test-command sequencer: runs host command lines as chip register accesses.
// Assumes an upstream character receiver and downstream transmitter on ref_clk_i,
// a chip access port with a level request and one-cycle ack, and an APB master.
`timescale 1ns/1ps
`include "mtcs_defines.svh"
module modem_test_command_sequencer #(
    parameter int unsigned TENTH_CYCLES = `MTCS_TENTH_SEC_NS / `MTCS_CLK_PERIOD_NS
) (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic rx_valid_i,
    input wire logic [7:0] rx_char_i,
    output logic rx_ready_o,
    output logic tx_valid_o,
    output logic [7:0] tx_char_o,
    input wire logic tx_ready_i,
    output logic chip_req_o,
    output logic chip_wr_o,
    output logic [7:0] chip_addr_o,
    output logic [15:0] chip_wdata_o,
    input wire logic chip_ack_i,
    input wire logic [15:0] chip_rdata_i,
    input wire logic chip_interrupt_n_i,
    input wire logic carrier_det_i,
    output logic hook_off_o,
    output logic irq_o
);
    localparam logic [8*20-1:0] MSG = "OK\rERROR\rNO CARRIER\r";
    mtcs_pkg::seq_state_s q;
    mtcs_pkg::seq_state_s d;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [3:0] dig;
    logic is_dig;
    logic [3:0] nib;
    logic [31:0] hang_lim;
    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] hex_char(input logic [3:0] n);
        hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
    endfunction
    function automatic logic [7:0] msg_char(input logic [4:0] i);
        msg_char = MSG[8 * (19 - int'(i)) +: 8];
    endfunction
    assign dig = q.ch[3:0];
    assign is_dig = (q.ch >= 8'h30) && (q.ch <= 8'h39);
    assign hang_lim = 32'(32'(q.ctrl[7:0]) * TENTH_CYCLES);
    always_comb begin
        case (q.snd_idx[1:0])
            2'h0: nib = q.rd_val[15:12];
            2'h1: nib = q.rd_val[11:8];
            2'h2: nib = q.rd_val[7:4];
            default: nib = q.rd_val[3:0];
        endcase
    end
    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        d = q;
        ev = 3'h0;
        clr = 3'h0;
        d.irq_sync = {q.irq_sync[0], chip_interrupt_n_i};
        d.cd_sync = {q.cd_sync[0], carrier_det_i};
        d.pready = 1'b0;
        d.pslverr = 1'b0;
        // APB slave: answer one cycle into the access phase
        if (psel_i && penable_i && !q.pready) begin
            d.pready = 1'b1;
            d.prdata = 32'h0;
            case (paddr_i)
                `MTCS_CTRL_ADDR: d.prdata = {23'h0, q.ctrl};
                `MTCS_IRQ_ST_ADDR: d.prdata = {29'h0, q.irq_st};
                `MTCS_IRQ_MK_ADDR: d.prdata = {29'h0, q.irq_mk};
                `MTCS_STATE_ADDR: begin
                    d.prdata[0] = q.sh_tx[`MTCS_MODE_HI:`MTCS_MODE_LO] == `MTCS_MODE_TONES;
                    d.prdata[1] = q.sh_tx[`MTCS_LEVEL_HI:`MTCS_LEVEL_LO] == `MTCS_LEVEL_0DB;
                    d.prdata[2] = q.sh_tx[3:0] != `MTCS_TONE_OFF;
                    d.prdata[3] = q.sh_tx[3:0] == `MTCS_TONE_A;
                    d.prdata[4] = q.sh_tx[3:0] == `MTCS_TONE_B;
                    d.prdata[5] = q.sh_rx[`MTCS_MODE_HI:`MTCS_MODE_LO] == `MTCS_MODE_TONES;
                    d.prdata[6] = q.sh_gc[`MTCS_GC_XTAL];
                    d.prdata[7] = q.sh_gc[`MTCS_GC_EQU_DIS];
                    d.prdata[8] = q.sh_gc[`MTCS_GC_OFF_HOOK];
                    d.prdata[9] = q.sh_gc[`MTCS_GC_PWR_UP];
                    d.prdata[10] = !q.sh_gc[`MTCS_GC_RESET];
                    d.prdata[11] = q.sh_gc[`MTCS_GC_IRQ_EN];
                    d.prdata[12] = q.hook;
                    d.prdata[15:13] = q.st;
                    d.prdata[19:16] = q.ps;
                end
                {2'h0, `MTCS_GC_IDX, 2'h0}: d.prdata = {16'h0, q.sh_gc};
                {2'h0, `MTCS_TX_IDX, 2'h0}: d.prdata = {16'h0, q.sh_tx};
                {2'h0, `MTCS_RX_IDX, 2'h0}: d.prdata = {16'h0, q.sh_rx};
                {2'h0, `MTCS_ST_IDX, 2'h0}: d.prdata = {16'h0, q.sh_stat};
                default: d.pslverr = 1'b1;
            endcase
        end
        if (psel_i && penable_i && q.pready && pwrite_i && !q.pslverr) begin
            case (paddr_i)
                `MTCS_CTRL_ADDR: d.ctrl = pwdata_i[8:0];
                `MTCS_IRQ_ST_ADDR: clr = pwdata_i[2:0];
                `MTCS_IRQ_MK_ADDR: d.irq_mk = pwdata_i[2:0];
                default: d.ctrl = q.ctrl;
            endcase
        end
        // Carrier loss timer while watching and off hook
        if (q.ctrl[8] && q.hook && !q.cd_sync[1] && !q.cd_lost) begin
            d.cd_cnt = q.cd_cnt + 32'h1;
            if (q.cd_cnt >= hang_lim) begin
                d.cd_lost = 1'b1;
                d.cd_cnt = 32'h0;
            end
        end else begin
            d.cd_cnt = 32'h0;
        end
        unique case (q.st)
            mtcs_pkg::S_IDLE: begin
                if (q.cd_lost) begin
                    // Hang up, then report no carrier
                    d.cd_lost = 1'b0;
                    d.hook = 1'b0;
                    d.snd_hex = 1'b0;
                    d.snd_last = 1'b0;
                    d.snd_idx = `MTCS_MSG_NOCAR;
                    d.ps = mtcs_pkg::P_A;
                    d.st = mtcs_pkg::S_SEND;
                    ev[1] = 1'b1;
                end else if (rx_valid_i && q.rx_ready) begin
                    d.ch = rx_char_i;
                    d.st = mtcs_pkg::S_DEC;
                end
            end
            mtcs_pkg::S_DEC: begin
                d.st = mtcs_pkg::S_IDLE;
                // One sub-command at a time, left to right
                unique case (q.ps)
                    mtcs_pkg::P_A: d.ps = (q.ch == "A") ? mtcs_pkg::P_T : mtcs_pkg::P_SKIP;
                    mtcs_pkg::P_T: d.ps = (q.ch == "T") ? mtcs_pkg::P_CMD : mtcs_pkg::P_SKIP;
                    mtcs_pkg::P_CMD: begin
                        if (q.ch == "H") d.ps = mtcs_pkg::P_H;
                        else if (q.ch == "@") d.ps = mtcs_pkg::P_AT;
                        else if (q.ch != `MTCS_CR) d.ps = mtcs_pkg::P_SKIP;
                    end
                    mtcs_pkg::P_H: begin
                        d.ps = mtcs_pkg::P_CMD;
                        if (q.ch == "1") d.hook = 1'b1;
                        else if (q.ch == "0") d.hook = 1'b0;
                        else d.ps = mtcs_pkg::P_SKIP;
                    end
                    mtcs_pkg::P_AT: begin
                        if (q.ch == "R") d.ps = mtcs_pkg::P_R;
                        else if (q.ch == "F") d.ps = mtcs_pkg::P_F;
                        else d.ps = mtcs_pkg::P_SKIP;
                    end
                    mtcs_pkg::P_R: d.ps = (q.ch == "E") ? mtcs_pkg::P_E : mtcs_pkg::P_SKIP;
                    mtcs_pkg::P_E: begin
                        d.creg = dig;
                        d.ps = is_dig ? mtcs_pkg::P_REG : mtcs_pkg::P_SKIP;
                    end
                    mtcs_pkg::P_REG: begin
                        d.acc = 16'h0;
                        d.addr = `MTCS_CHIP_BASE | {4'h0, q.creg};
                        if (q.ch == "?") begin
                            d.req = 1'b1;
                            d.wr = 1'b0;
                            d.ps = mtcs_pkg::P_CMD;
                            d.st = mtcs_pkg::S_CHIP;
                        end else begin
                            d.ps = (q.ch == "=") ? mtcs_pkg::P_NUM : mtcs_pkg::P_SKIP;
                        end
                    end
                    mtcs_pkg::P_NUM: begin
                        if (is_dig) begin
                            d.acc = 16'(q.acc * 16'd10 + {12'h0, dig});
                        end else begin
                            // Write, then decode this character again
                            d.req = 1'b1;
                            d.wr = 1'b1;
                            d.wdata = q.acc;
                            d.ps = mtcs_pkg::P_CMD;
                            d.st = mtcs_pkg::S_CHIP;
                        end
                    end
                    mtcs_pkg::P_F: begin
                        d.ps = mtcs_pkg::P_CMD;
                        if (q.ch == "2") begin
                            d.cnt = TENTH_CYCLES - 32'h1;
                            d.st = mtcs_pkg::S_DELAY;
                        end else if (q.ch == "7") begin
                            d.st = mtcs_pkg::S_WIRQ;
                        end else begin
                            d.ps = mtcs_pkg::P_SKIP;
                        end
                    end
                    mtcs_pkg::P_SKIP: d.ps = mtcs_pkg::P_SKIP;
                endcase
                if (d.ps == mtcs_pkg::P_SKIP) d.line_err = 1'b1;
                if (q.ch == `MTCS_CR && d.st == mtcs_pkg::S_IDLE) begin
                    if (d.line_err) ev[2] = 1'b1;
                    d.snd_hex = 1'b0;
                    d.snd_last = 1'b0;
                    d.snd_idx = d.line_err ? `MTCS_MSG_ERROR : `MTCS_MSG_OK;
                    d.line_err = 1'b0;
                    d.ps = mtcs_pkg::P_A;
                    d.st = mtcs_pkg::S_SEND;
                end
            end
            mtcs_pkg::S_CHIP: begin
                if (chip_ack_i) begin
                    d.req = 1'b0;
                    if (q.wr) begin
                        if (q.addr == `MTCS_GC_IDX) d.sh_gc = q.wdata;
                        if (q.addr == `MTCS_TX_IDX) d.sh_tx = q.wdata;
                        if (q.addr == `MTCS_RX_IDX) d.sh_rx = q.wdata;
                        d.st = mtcs_pkg::S_DEC;
                    end else begin
                        if (q.addr == `MTCS_ST_IDX) d.sh_stat = chip_rdata_i;
                        d.rd_val = chip_rdata_i;
                        d.snd_hex = 1'b1;
                        d.snd_last = 1'b0;
                        d.snd_idx = 5'h0;
                        d.st = mtcs_pkg::S_SEND;
                        ev[0] = 1'b1;
                    end
                end
            end
            mtcs_pkg::S_DELAY: begin
                if (q.cnt == 32'h0) d.st = mtcs_pkg::S_IDLE;
                else d.cnt = q.cnt - 32'h1;
            end
            mtcs_pkg::S_WIRQ: begin
                // Stall until interrupt, then read status
                if (!q.irq_sync[1]) begin
                    d.req = 1'b1;
                    d.wr = 1'b0;
                    d.addr = `MTCS_ST_IDX;
                    d.st = mtcs_pkg::S_CHIP;
                end
            end
            mtcs_pkg::S_SEND: begin
                if (q.tx_valid) begin
                    if (tx_ready_i) d.tx_valid = 1'b0;
                end else if (q.snd_last) begin
                    d.snd_last = 1'b0;
                    d.st = mtcs_pkg::S_IDLE;
                end else begin
                    d.tx_valid = 1'b1;
                    d.snd_idx = q.snd_idx + 5'h1;
                    if (q.snd_hex) begin
                        d.tx_char = (q.snd_idx == 5'h4) ? `MTCS_CR : hex_char(nib);
                        d.snd_last = q.snd_idx == 5'h4;
                    end else begin
                        d.tx_char = msg_char(q.snd_idx);
                        d.snd_last = msg_char(q.snd_idx) == `MTCS_CR;
                    end
                end
            end
        endcase
        // Sticky events, set wins over clear
        d.irq_st = (q.irq_st & ~clr) | ev;
        d.irq = |(d.irq_st & d.irq_mk);
        d.rx_ready = (d.st == mtcs_pkg::S_IDLE) && !d.cd_lost;
    end
    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            q <= '0;
            q.st <= mtcs_pkg::S_IDLE;
            q.ps <= mtcs_pkg::P_A;
            q.ctrl <= `MTCS_CTRL_RST;
            q.irq_mk <= `MTCS_IRQ_RST;
            q.irq_sync <= 2'h3;
            q.cd_sync <= 2'h3;
        end else begin
            q <= d;
        end
    end
    assign prdata_o = q.prdata;
    assign pready_o = q.pready;
    assign pslverr_o = q.pslverr;
    assign rx_ready_o = q.rx_ready;
    assign tx_valid_o = q.tx_valid;
    assign tx_char_o = q.tx_char;
    assign chip_req_o = q.req;
    assign chip_wr_o = q.wr;
    assign chip_addr_o = q.addr;
    assign chip_wdata_o = q.wdata;
    assign hook_off_o = q.hook;
    assign irq_o = q.irq;
    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    a_hook_seize: assert property (
        q.st == mtcs_pkg::S_DEC && q.ps == mtcs_pkg::P_H && q.ch == "1"
        |=> hook_off_o && !chip_req_o)
        else $error("off-hook command did not seize line");
    a_delay_hold: assert property (
        q.st == mtcs_pkg::S_DELAY && q.cnt != 32'h0 |=> q.st == mtcs_pkg::S_DELAY)
        else $error("pause ended early");
    a_dec_convert: assert property (
        q.st == mtcs_pkg::S_DEC && q.ps == mtcs_pkg::P_NUM && is_dig
        |=> q.acc == 16'($past(q.acc) * 16'd10 + {12'h0, $past(dig)}))
        else $error("decimal conversion wrong");
    a_query_reply: assert property (
        q.st == mtcs_pkg::S_CHIP && !q.wr && chip_ack_i
        |=> q.st == mtcs_pkg::S_SEND && q.snd_hex && q.rd_val == $past(chip_rdata_i))
        else $error("read not reported as text");
    a_irq_stall: assert property (
        q.st == mtcs_pkg::S_WIRQ && q.irq_sync[1] |=> q.st == mtcs_pkg::S_WIRQ && !chip_req_o)
        else $error("interrupt wait did not stall");
    a_gc_shadow: assert property (
        q.st == mtcs_pkg::S_CHIP && q.wr && chip_ack_i && q.addr == `MTCS_GC_IDX
        |=> q.sh_gc == $past(chip_wdata_o))
        else $error("general control shadow not updated");
    a_irq_status: assert property (
        q.st == mtcs_pkg::S_WIRQ && !q.irq_sync[1]
        |=> chip_req_o && !chip_wr_o && chip_addr_o == `MTCS_ST_IDX)
        else $error("interrupt did not read status");
    a_hangup_msg: assert property (
        q.st == mtcs_pkg::S_IDLE && q.cd_lost
        |=> !hook_off_o ##1 tx_valid_o && tx_char_o == "N")
        else $error("carrier loss did not hang up");
    a_in_order: assert property (
        rx_ready_o |-> q.st == mtcs_pkg::S_IDLE && !chip_req_o && !tx_valid_o)
        else $error("input accepted while busy");
endmodule

// >>> tb/mtcs_host_model.sv
// Host terminal model: sends command lines and keeps the last eight reply chars.
// Assumes the sequencer's character ports run on the same clock.
`timescale 1ns/1ps
module mtcs_host_model (
    input wire logic clk_i,
    input wire logic slow_i,
    input wire logic rx_ready_i,
    output logic rx_valid_o,
    output logic [7:0] rx_char_o,
    input wire logic tx_valid_i,
    input wire logic [7:0] tx_char_i,
    output logic tx_ready_o,
    output logic [63:0] last_o,
    output logic hang_o
);
    initial begin
        rx_valid_o = 1'b0;
        rx_char_o = 8'h00;
        tx_ready_o = 1'b1;
        last_o = '0;
        hang_o = 1'b0;
    end
    // Reply sink, stalls every other cycle when slow
    always @(posedge clk_i) begin
        if (tx_valid_i && tx_ready_o) begin
            last_o <= {last_o[55:0], tx_char_i};
        end
        tx_ready_o <= slow_i ? ~tx_ready_o : 1'b1;
    end
    task automatic send_line(input string s);
        int k;
        for (int i = 0; i < s.len(); i++) begin
            @(posedge clk_i);
            rx_valid_o <= 1'b1;
            rx_char_o <= s[i];
            k = 0;
            do begin
                @(posedge clk_i);
                k++;
            end while (!rx_ready_i && k < 5000);
            hang_o <= hang_o | (k >= 5000);
            rx_valid_o <= 1'b0;
            rx_char_o <= ~s[i];
        end
    endtask
endmodule

// >>> tb/modem_test_command_sequencer_tb_top.sv
// Testbench: APB master, chip responder, host model and scenarios.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ps
module modem_test_command_sequencer_tb_top;
    localparam int TC = 200;
    logic clk, rst_n, psel, pen, pwr, pready, pslverr, rxv, rxr, txv, txr;
    logic creq, cwr, ack, chip_interrupt_n, cd, hook, irq, slow, hang;
    logic [11:0] paddr;
    logic [31:0] pwd, prd, r;
    logic [7:0] rxc, txc, caddr;
    logic [15:0] cwd, rdat;
    logic [63:0] last;
    logic e;
    logic [7:0] wa[$];
    logic [15:0] wd[$];
    int wt[$];
    int cyc, ccnt, nrd, hook_t, err_total, n_checks, k;
    logic [15:0] tw[4] = '{16'h1e1d, 16'h1e00, 16'h1e1e, 16'h1e00};

    modem_test_command_sequencer #(.TENTH_CYCLES(TC)) modem_test_command_sequencer_inst (
        .ref_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwd), .prdata_o(prd), .pready_o(pready),
        .pslverr_o(pslverr), .rx_valid_i(rxv), .rx_char_i(rxc), .rx_ready_o(rxr),
        .tx_valid_o(txv), .tx_char_o(txc), .tx_ready_i(txr), .chip_req_o(creq),
        .chip_wr_o(cwr), .chip_addr_o(caddr), .chip_wdata_o(cwd), .chip_ack_i(ack),
        .chip_rdata_i(rdat), .chip_interrupt_n_i(chip_interrupt_n), .carrier_det_i(cd),
        .hook_off_o(hook), .irq_o(irq));
    mtcs_host_model mtcs_host_model_inst (.clk_i(clk), .slow_i(slow), .rx_ready_i(rxr),
        .rx_valid_o(rxv), .rx_char_o(rxc), .tx_valid_i(txv), .tx_char_i(txc),
        .tx_ready_o(txr), .last_o(last), .hang_o(hang));

    // ------------------------------------------------------------------
    // Chip responder: ack after three cycles, log accesses
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        ack <= 1'b0;
        rdat <= ~16'h1a2b;
        cyc <= cyc + 1;
        if (hook && hook_t == 0) begin
            hook_t <= cyc;
        end
        if (creq && !ack) begin
            ccnt <= ccnt + 1;
            if (ccnt == 2) begin
                ack <= 1'b1;
                ccnt <= 0;
                rdat <= 16'h1a2b;
                if (cwr) begin
                    wa.push_back(caddr);
                    wd.push_back(cwd);
                    wt.push_back(cyc);
                end else begin
                    nrd <= nrd + 1;
                    chip_interrupt_n <= 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("checks=%0d mismatches=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic lim(input int n, input int m);
        if (n >= m || hang) begin
            err_total++;
            print_verdict();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (!pready && k < 50);
        lim(k, 50);
        r = prd;
        e = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic idle();
        repeat (2) @(posedge clk);
        k = 0;
        while (!rxr && k < 3000) begin
            @(posedge clk);
            k++;
        end
        lim(k, 3000);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_tones();
        mtcs_host_model_inst.send_line("ATH1@RE1=7709@F2@RE1=7680@F2@RE1=7710@F2@RE1=7680\r");
        idle();
        chk(hook_t < wt[0] && hook, 1);
        for (int i = 0; i < 4; i++) begin
            chk({wa[i], wd[i]}, {8'he1, tw[i]});
        end
        for (int i = 0; i < 3; i++) begin
            chk(wt[i + 1] - wt[i] >= TC, 1);
        end
        chk(last[23:0], "OK\r");
    endtask
    task automatic t_rx();
        wa.delete();
        wd.delete();
        slow <= 1'b1;
        apb(1'b1, 12'h008, 32'h1);
        fork
            mtcs_host_model_inst.send_line("AT@RE0=5953@RE2=7681@RE6?@F7@F7@F7@F7@F7\r");
            for (int i = 0; i < 5; i++) begin
                repeat (i == 0 ? 400 : 60) @(posedge clk);
                chk(nrd, i + 1);
                chip_interrupt_n <= 1'b0;
            end
        join
        idle();
        chk(nrd, 6);
        chk({wa[0], wd[0], wa[1], wd[1]}, {8'he0, 16'h1741, 8'he2, 16'h1e01});
        chk(last, "1A2B\rOK\r");
        chk(irq, 1);
        apb(1'b1, 12'h004, 32'h1);
        repeat (2) @(posedge clk);
        chk(irq, 0);
        apb(1'b0, 12'h7f0, 32'h0);
        chk(e, 1);
        apb(1'b0, 12'h00c, 32'h0);
        chk(r & 32'h1fff, 32'h1fe3);
    endtask
    task automatic t_carrier();
        apb(1'b1, 12'h000, 32'h101);
        cd <= 1'b0;
        repeat (TC - 10) @(posedge clk);
        chk(hook, 1);
        k = 0;
        while (last[63:0] !== "CARRIER\r" && k < 800) begin
            @(posedge clk);
            k++;
        end
        lim(k, 800);
        chk(hook, 0);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h2);
    endtask

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst_n, psel, pen, pwr, ack, slow, cyc, ccnt, nrd, hook_t} = '0;
        {paddr, pwd, rdat, err_total, n_checks} = '0;
        chip_interrupt_n = 1'b1;
        cd = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        t_tones();
        t_rx();
        t_carrier();
        print_verdict();
    end
endmodule
